// file: logic/i2c_rs_pkg.sv
/*
 Constants and state types for the repeated-start and stop sequencer
 with bus collision detection.
 Assumes a single system clock of 10 MHz and no software registers.
*/
package i2c_rs_pkg;
    localparam int RELOAD_W = 7;
    localparam logic [6:0] RELOAD_ZERO = 7'h00;
    localparam logic [6:0] RELOAD_ONE = 7'h01;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RS_SDA_REL,
        ST_RS_CNT1,
        ST_RS_SCL_WAIT,
        ST_RS_CNT2,
        ST_RS_CNT3,
        ST_SP_SDA_LOW,
        ST_SP_SCL_WAIT,
        ST_SP_CNT1,
        ST_SP_SDA_CHK
    } seq_state_t;
endpackage

// file: logic/baud_down_counter.sv
/*
 Reloadable seven-bit down counter that paces bus conditions.
 Assumes load and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module baud_down_counter (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic run,
    input wire logic [6:0] reload_value,
    output logic timeout
);
    logic [6:0] count_r;
    logic [6:0] count_nxt;

    assign count_nxt = load ? reload_value :
        ((run && count_r != i2c_rs_pkg::RELOAD_ZERO) ?
        count_r - i2c_rs_pkg::RELOAD_ONE : count_r);
    // Independent of load, so no loop through the caller's decode
    assign timeout = run && count_r == i2c_rs_pkg::RELOAD_ZERO;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= i2c_rs_pkg::RELOAD_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule

// file: logic/i2c_master_restart_stop_collision.sv
/*
 Repeated-start and stop sequencer of a two-wire bus master, with bus
 collision detection and abort.
 Assumes open-drain pins resolved outside; scl_in and sda_in are
 asynchronous and are synchronised here. Requests are level bits of
 master_sequence_control driven by the host core on sys_clk.
*/
// Operation
// - A zero on SDA when SCL rises during a repeated-start is a collision.
// - SCL falling before SDA is driven low in a repeated-start collides.
// - With SDA released and high, the counter loads and counts to zero.
// - After that count SCL is released and SDA sampled once SCL is high.
// - SDA low when SCL is sampled high in a repeated-start collides.
// - SDA high there reloads the counter; a later SDA fall is no collision.
// - SCL falling before timeout with SDA not yet driven collides.
// - Both lines high at timeout drive SDA low and reload the counter.
// - At the end of the final count SCL is driven low and it completes.
// - A stop drives SDA low, releases SCL, then counts once SCL is high.
// - In a stop, SDA still low after release and timeout collides.
// - In a stop, SCL low after release and before SDA is high collides.
// - Any collision sets the collision flag and returns to idle.
// - A collision releases both lines and clears the request bits.
// - A released SCL holds the counter until SCL is sampled high.
`timescale 1ns/1ps
module i2c_master_restart_stop_collision (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic restart_req,
    input wire logic stop_req,
    input wire logic [6:0] baud_reload_value,
    input wire logic flag_clear,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic restart_en,
    output logic stop_en,
    output logic collision_irq_flag,
    output logic done_pulse,
    output logic busy
);
    i2c_rs_pkg::seq_state_t state_r, state_nxt;
    logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, scl_prev_r;
    logic rs_en_r, sp_en_r, flag_r;
    logic scl_drv_r, sda_drv_r, scl_drv_nxt, sda_drv_nxt;
    logic done_r, sda_early_r, sda_early_nxt;
    logic cnt_load, cnt_run, cnt_to;
    logic scl_rise, scl_fall, collide, finish;

    default clocking sva_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // Two-stage synchronisers for the bus lines
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_m_r <= 1'h1;
            scl_s_r <= 1'h1;
            sda_m_r <= 1'h1;
            sda_s_r <= 1'h1;
            scl_prev_r <= 1'h1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            scl_prev_r <= scl_s_r;
        end
    end

    assign scl_rise = scl_s_r && !scl_prev_r;
    assign scl_fall = !scl_s_r && scl_prev_r;

    baud_down_counter u_cnt (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(cnt_load),
        .run(cnt_run),
        .reload_value(baud_reload_value),
        .timeout(cnt_to)
    );

    always_comb begin
        state_nxt = state_r;
        scl_drv_nxt = scl_drv_r;
        sda_drv_nxt = sda_drv_r;
        sda_early_nxt = sda_early_r;
        cnt_load = 1'h0;
        cnt_run = 1'h0;
        collide = 1'h0;
        finish = 1'h0;
        case (state_r)
            i2c_rs_pkg::ST_IDLE: begin
                sda_early_nxt = 1'h0;
                if (rs_en_r) begin
                    sda_drv_nxt = 1'h0;
                    state_nxt = i2c_rs_pkg::ST_RS_SDA_REL;
                end else if (sp_en_r) begin
                    sda_drv_nxt = 1'h1;
                    state_nxt = i2c_rs_pkg::ST_SP_SDA_LOW;
                end
            end
            i2c_rs_pkg::ST_RS_SDA_REL: begin
                if (sda_s_r) begin
                    cnt_load = 1'h1;
                    state_nxt = i2c_rs_pkg::ST_RS_CNT1;
                end
            end
            i2c_rs_pkg::ST_RS_CNT1: begin
                cnt_run = 1'h1;
                if (cnt_to) begin
                    scl_drv_nxt = 1'h0;
                    state_nxt = i2c_rs_pkg::ST_RS_SCL_WAIT;
                end
            end
            i2c_rs_pkg::ST_RS_SCL_WAIT: begin
                if (scl_s_r) begin
                    if (!sda_s_r) begin
                        collide = 1'h1;
                    end else begin
                        cnt_load = 1'h1;
                        state_nxt = i2c_rs_pkg::ST_RS_CNT2;
                    end
                end
            end
            i2c_rs_pkg::ST_RS_CNT2: begin
                cnt_run = 1'h1;
                if (!sda_s_r) begin
                    sda_early_nxt = 1'h1;
                end
                if (scl_fall && sda_s_r && !sda_early_r) begin
                    collide = 1'h1;
                end else if (cnt_to) begin
                    sda_drv_nxt = 1'h1;
                    cnt_load = 1'h1;
                    state_nxt = i2c_rs_pkg::ST_RS_CNT3;
                end
            end
            i2c_rs_pkg::ST_RS_CNT3: begin
                cnt_run = 1'h1;
                if (cnt_to) begin
                    scl_drv_nxt = 1'h1;
                    finish = 1'h1;
                end
            end
            i2c_rs_pkg::ST_SP_SDA_LOW: begin
                if (!sda_s_r) begin
                    scl_drv_nxt = 1'h0;
                    state_nxt = i2c_rs_pkg::ST_SP_SCL_WAIT;
                end
            end
            i2c_rs_pkg::ST_SP_SCL_WAIT: begin
                if (scl_s_r) begin
                    cnt_load = 1'h1;
                    state_nxt = i2c_rs_pkg::ST_SP_CNT1;
                end
            end
            i2c_rs_pkg::ST_SP_CNT1: begin
                cnt_run = 1'h1;
                if (!scl_s_r) begin
                    collide = 1'h1;
                end else if (cnt_to) begin
                    sda_drv_nxt = 1'h0;
                    cnt_load = 1'h1;
                    state_nxt = i2c_rs_pkg::ST_SP_SDA_CHK;
                end
            end
            i2c_rs_pkg::ST_SP_SDA_CHK: begin
                cnt_run = 1'h1;
                if (!scl_s_r && !sda_s_r) begin
                    collide = 1'h1;
                end else if (cnt_to) begin
                    if (!sda_s_r) begin
                        collide = 1'h1;
                    end else begin
                        finish = 1'h1;
                    end
                end
            end
            default: begin
                collide = 1'h1;
            end
        endcase
        if (collide || finish) begin
            state_nxt = i2c_rs_pkg::ST_IDLE;
        end
        if (collide) begin
            scl_drv_nxt = 1'h0;
            sda_drv_nxt = 1'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= i2c_rs_pkg::ST_IDLE;
            scl_drv_r <= 1'h0;
            sda_drv_r <= 1'h0;
            sda_early_r <= 1'h0;
            done_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            scl_drv_r <= scl_drv_nxt;
            sda_drv_r <= sda_drv_nxt;
            sda_early_r <= sda_early_nxt;
            done_r <= finish;
        end
    end

    // Request bits cleared on end or abort
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rs_en_r <= 1'h0;
            sp_en_r <= 1'h0;
        end else if (collide || finish) begin
            rs_en_r <= 1'h0;
            sp_en_r <= 1'h0;
        end else if (state_r == i2c_rs_pkg::ST_IDLE && !rs_en_r &&
            !sp_en_r) begin
            rs_en_r <= restart_req;
            sp_en_r <= stop_req && !restart_req;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= 1'h0;
        end else if (collide) begin
            flag_r <= 1'h1;
        end else if (flag_clear) begin
            flag_r <= 1'h0;
        end
    end

    assign scl_out = 1'h0;
    assign sda_out = 1'h0;
    assign scl_oe = scl_drv_r;
    assign sda_oe = sda_drv_r;
    assign restart_en = rs_en_r;
    assign stop_en = sp_en_r;
    assign collision_irq_flag = flag_r;
    assign done_pulse = done_r;
    assign busy = state_r != i2c_rs_pkg::ST_IDLE;

    AST_COLL_FLAG: assert property (
        collide |=> collision_irq_flag && !busy)
        else $error("collision did not flag and idle");
    AST_COLL_REL: assert property (
        collide |=> !scl_oe && !sda_oe && !restart_en && !stop_en)
        else $error("abort left lines driven");
    AST_RS_DONE: assert property (
        state_r == i2c_rs_pkg::ST_RS_CNT3 && cnt_to
        |=> scl_oe && sda_oe && done_pulse)
        else $error("restart end wrong");
    AST_RS_SDA: assert property (
        state_r == i2c_rs_pkg::ST_RS_CNT2 && cnt_to && !scl_fall
        |=> sda_oe)
        else $error("restart SDA not driven");
    // SDA low at SCL high collides
    AST_RS_SDA0: assert property (
        state_r == i2c_rs_pkg::ST_RS_SCL_WAIT && scl_s_r && !sda_s_r
        |=> collision_irq_flag)
        else $error("missed restart SDA collision");
    // SDA low at SCL rise collides
    AST_RS_RISE: assert property (
        state_r == i2c_rs_pkg::ST_RS_SCL_WAIT && scl_rise && !sda_s_r
        |=> collision_irq_flag && !busy)
        else $error("missed restart SDA collision at SCL rise");
    // No counting while SCL held low
    AST_STRETCH: assert property (
        (state_r == i2c_rs_pkg::ST_RS_SCL_WAIT ||
        state_r == i2c_rs_pkg::ST_SP_SCL_WAIT) && !scl_s_r
        |-> !cnt_load && !cnt_run)
        else $error("counter ran during stretch");
    AST_SP_START: assert property (
        state_r == i2c_rs_pkg::ST_IDLE && sp_en_r && !rs_en_r
        |=> sda_oe && scl_oe == $past(scl_oe))
        else $error("stop did not drive SDA");
    AST_SP_SCL: assert property (
        state_r == i2c_rs_pkg::ST_SP_CNT1 && !scl_s_r
        |=> collision_irq_flag && !scl_oe)
        else $error("missed stop SCL collision");
    AST_SP_SDA: assert property (
        state_r == i2c_rs_pkg::ST_SP_SDA_CHK && cnt_to && !sda_s_r
        |=> collision_irq_flag)
        else $error("missed stop SDA collision");
endmodule

// file: tb/i2c_bus_partner.sv
/*
 Other masters and slaves sharing the two-wire bus with the sequencer.
 Assumes pull-ups on both lines and hold commands given by the bench.
*/
`timescale 1ns/1ps
module i2c_bus_partner (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic hold_scl,
    input wire logic hold_sda,
    output logic scl_in,
    output logic sda_in
);
    assign scl_in = ~(scl_oe | hold_scl);
    assign sda_in = ~(sda_oe | hold_sda);
endmodule

// file: tb/i2c_master_restart_stop_collision_tb.sv
/*
 Self-checking bench for the repeated-start and stop sequencer.
 Assumes the bus partner resolves both open-drain lines.
*/
`timescale 1ns/1ps
module i2c_master_restart_stop_collision_tb;
    localparam int R = 10;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic restart_req = 1'h0;
    logic stop_req = 1'h0;
    logic flag_clear = 1'h0;
    logic hold_scl = 1'h0;
    logic hold_sda = 1'h0;
    logic [6:0] baud_reload_value = 7'h0A;
    logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
    logic restart_en, stop_en, collision_irq_flag, done_pulse, busy;
    logic [5:0] ev;
    int fail_count = 0;
    int compares = 0;
    assign ev = {restart_en | stop_en, ~scl_oe, ~sda_oe, sda_oe,
        collision_irq_flag, done_pulse};
    always #50 sys_clk = ~sys_clk;
    i2c_master_restart_stop_collision i_i2c_master_restart_stop_collision (
        .sys_clk(sys_clk), .resetn(resetn), .restart_req(restart_req),
        .stop_req(stop_req), .baud_reload_value(baud_reload_value),
        .flag_clear(flag_clear), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .restart_en(restart_en), .stop_en(stop_en),
        .collision_irq_flag(collision_irq_flag), .done_pulse(done_pulse),
        .busy(busy));
    i2c_bus_partner i_i2c_bus_partner (.scl_oe(scl_oe), .sda_oe(sda_oe),
        .hold_scl(hold_scl), .hold_sda(hold_sda), .scl_in(scl_in),
        .sda_in(sda_in));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic seen, input logic exp, input string m);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wait_ev(input int k);
        int i;
        i = 0;
        while (ev[k] !== 1'h1 && i < 300) begin
            cyc(1);
            i++;
        end
        check(ev[k], 1'h1, "awaited event missing");
    endtask
    task automatic do_reset();
        hold_scl = 1'h0;
        hold_sda = 1'h0;
        resetn = 1'h0;
        cyc(20);
        resetn = 1'h1;
        cyc(1);
    endtask
    task automatic request(input logic rs);
        restart_req = rs;
        stop_req = ~rs;
        wait_ev(5);
        restart_req = 1'h0;
        stop_req = 1'h0;
    endtask
    task automatic collided();
        wait_ev(1);
        cyc(2);
        check(collision_irq_flag, 1'h1, "flag lost");
        check(scl_oe | sda_oe, 1'h0, "lines still driven");
        check(restart_en | stop_en, 1'h0, "enables kept");
        check(busy, 1'h0, "not idle after collision");
        flag_clear = 1'h1;
        cyc(1);
        flag_clear = 1'h0;
        cyc(1);
        check(collision_irq_flag, 1'h0, "flag not cleared");
        do_reset();
    endtask
    task automatic t_restart_ok();
        request(1'h1);
        wait_ev(0);
        check(scl_oe & sda_oe, 1'h1, "restart end levels");
        check(collision_irq_flag, 1'h0, "false collision");
        cyc(1);
        check(restart_en | busy, 1'h0, "restart not finished");
    endtask
    task automatic t_restart_hold(input int mode);
        hold_scl = 1'h1;
        request(1'h1);
        cyc(R + 12);
        check(collision_irq_flag, 1'h0, "stretch as collision");
        if (mode == 0) begin
            hold_sda = 1'h1;
            hold_scl = 1'h0;
            collided();
        end else begin
            hold_scl = 1'h0;
            cyc(6);
            if (mode == 1) begin
                hold_scl = 1'h1;
                collided();
            end else begin
                hold_sda = 1'h1;
                cyc(3);
                check(collision_irq_flag, 1'h0, "early SDA fall");
                wait_ev(0);
                check(collision_irq_flag, 1'h0, "late flag");
                do_reset();
            end
        end
    endtask
    task automatic t_stop(input int mode);
        hold_scl = 1'h1;
        request(1'h0);
        wait_ev(2);
        cyc(R + 10);
        check(busy & sda_oe, 1'h1, "stop left wait");
        hold_scl = 1'h0;
        if (mode == 0) begin
            wait_ev(0);
            check(scl_oe | sda_oe, 1'h0, "stop end levels");
            check(collision_irq_flag, 1'h0, "false collision");
            cyc(1);
            check(stop_en | busy, 1'h0, "stop not finished");
        end else if (mode == 1) begin
            wait_ev(3);
            hold_sda = 1'h1;
            collided();
        end else begin
            cyc(4);
            hold_scl = 1'h1;
            collided();
        end
    endtask
    initial begin
        #3000000;
        fail_count++;
        stop_test();
    end
    initial begin
        do_reset();
        check(scl_oe | sda_oe | busy, 1'h0, "reset levels");
        check(collision_irq_flag | done_pulse, 1'h0, "reset flags");
        check(scl_out | sda_out, 1'h0, "open-drain data not low");
        t_restart_ok();
        t_restart_hold(0);
        t_restart_hold(1);
        t_restart_hold(2);
        t_stop(0);
        t_stop(1);
        t_stop(2);
        stop_test();
    end
endmodule
